// File: cdwit_pkg.sv
// Shared constants and packed types of the countdown watchdog / interval timer
package cdwit_pkg;

    localparam int COUNT_W = 24;
    localparam int PRESCALE_W = 4;
    localparam int DIV_W = 16;
    localparam int KEY_W = 8;

    // Clock period of the system clock, for reference by the bench
    localparam int CLOCK_PERIOD_NS = 10;

    localparam logic [COUNT_W-1:0] COUNT_ZERO = 24'h00_0000;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 24'h00_0001;
    localparam logic [COUNT_W-1:0] RELOAD_RESET = 24'hFF_FFFF;

    // Key value that turns a control write into a restart
    localparam logic [KEY_W-1:0] RESTART_KEY = 8'h5A;

    localparam logic CLKSEL_REF = 1'b0;
    localparam logic CLKSEL_PLL = 1'b1;

    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 4'h0;
    localparam logic [PRESCALE_W:0] PRESCALE_STEP = 5'h01;
    localparam logic [DIV_W:0] DIV_ONE = 17'h0_0001;
    localparam logic [DIV_W-1:0] DIV_ZERO = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_STEP = 16'h0001;

    typedef enum logic {
        PH_ARMED,
        PH_WARNED
    } cdwit_phase_t;

    // Control word as written by software
    typedef struct packed {
        logic [KEY_W-1:0] restartKey;
        logic clearFlag;
        logic [PRESCALE_W-1:0] prescale;
        logic clkSel;
        logic resetEn;
        logic intervalEn;
    } cdwit_ctl_t;

    // Control readback
    typedef struct packed {
        logic writePending;
        logic irqFlag;
        logic [PRESCALE_W-1:0] prescale;
        logic clkSel;
        logic resetEn;
        logic intervalEn;
    } cdwit_status_t;

    typedef struct packed {
        logic [DIV_W-1:0] count;
        logic tick;
    } cdwit_div_state_t;

    localparam cdwit_div_state_t DIV_RESET = '{count: DIV_ZERO, tick: 1'b0};

endpackage

// File: cdwit_prescaler.sv
// Power-of-two prescaler producing one-cycle divided timer ticks
module cdwit_prescaler (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic srcTick,
    input wire logic [cdwit_pkg::PRESCALE_W-1:0] divSel,
    output logic divTick
);

    cdwit_pkg::cdwit_div_state_t state_reg;
    cdwit_pkg::cdwit_div_state_t state_next;
    logic [cdwit_pkg::DIV_W:0] maskWide;
    logic [cdwit_pkg::DIV_W-1:0] divMask;

    ////////////////////////////////////////////////////////////////////////////////

    // Select 0 divides by two, select 15 by 65536
    always_comb
    begin
        maskWide = (cdwit_pkg::DIV_ONE << ({1'b0, divSel} + cdwit_pkg::PRESCALE_STEP))
            - cdwit_pkg::DIV_ONE;
        divMask = maskWide[cdwit_pkg::DIV_W-1:0];
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (srcTick)
        begin
            // Masking lets a smaller ratio take effect without a long wrap
            if ((state_reg.count & divMask) == divMask)
            begin
                state_next.count = cdwit_pkg::DIV_ZERO;
                state_next.tick = 1'b1;
            end
            else
            begin
                state_next.count = state_reg.count + cdwit_pkg::DIV_STEP;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_reg <= cdwit_pkg::DIV_RESET;
        else
            state_reg <= state_next;
    end

    assign divTick = state_reg.tick;

    ////////////////////////////////////////////////////////////////////////////////

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_div_from_source: assert property ($rose(divTick) |-> $past(srcTick))
        else $error("Divided tick without a source tick");

    chk_div_min_ratio: assert property (divTick |=> !divTick)
        else $error("Divided ticks back to back");

endmodule

// File: cdwit_timer.sv
// Countdown timer usable as interval timer, watchdog, or both
module cdwit_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tickRef,
    input wire logic tickPll,
    input wire logic deepSleep,
    input wire logic ctlWrite,
    input wire cdwit_pkg::cdwit_ctl_t ctlWriteData,
    input wire logic reloadWrite,
    input wire logic [cdwit_pkg::COUNT_W-1:0] reloadWriteData,
    output logic [cdwit_pkg::COUNT_W-1:0] liveCount,
    output logic [cdwit_pkg::COUNT_W-1:0] reloadValue,
    output cdwit_pkg::cdwit_status_t ctlStatus,
    output logic irqReq,
    output logic wakeReq,
    output logic softReset
);

    typedef struct packed {
        cdwit_pkg::cdwit_ctl_t cfg;
        logic [cdwit_pkg::COUNT_W-1:0] reload;
        logic [cdwit_pkg::COUNT_W-1:0] count;
        cdwit_pkg::cdwit_ctl_t pendCtl;
        logic pendCtlValid;
        logic [cdwit_pkg::COUNT_W-1:0] pendReload;
        logic pendReloadValid;
        logic busy;
        logic flag;
        cdwit_pkg::cdwit_phase_t phase;
        logic softReset;
        logic wake;
        logic irq;
    } cdwit_state_t;

    localparam cdwit_pkg::cdwit_ctl_t CTL_RESET = '{
        restartKey: '0,
        clearFlag: 1'b0,
        prescale: cdwit_pkg::PRESCALE_RESET,
        clkSel: cdwit_pkg::CLKSEL_REF,
        resetEn: 1'b0,
        intervalEn: 1'b0
    };

    localparam cdwit_state_t STATE_RESET = '{
        cfg: CTL_RESET,
        reload: cdwit_pkg::RELOAD_RESET,
        count: cdwit_pkg::RELOAD_RESET,
        pendCtl: CTL_RESET,
        pendCtlValid: 1'b0,
        pendReload: cdwit_pkg::RELOAD_RESET,
        pendReloadValid: 1'b0,
        busy: 1'b0,
        flag: 1'b0,
        phase: cdwit_pkg::PH_ARMED,
        softReset: 1'b0,
        wake: 1'b0,
        irq: 1'b0
    };

    cdwit_state_t st_reg;
    cdwit_state_t st_next;
    logic srcTick;
    logic divTick;
    logic acceptNow;
    logic commitNow;
    logic restartNow;
    logic clearNow;
    logic runNow;
    logic expiryNow;
    logic [cdwit_pkg::COUNT_W-1:0] reloadNew;

    ////////////////////////////////////////////////////////////////////////////////

    // PLL output stops in deep sleep, so only the reference source keeps ticking
    always_comb
    begin
        if (st_reg.cfg.clkSel == cdwit_pkg::CLKSEL_REF)
            srcTick = tickRef;
        else
            srcTick = tickPll & ~deepSleep;
    end

    cdwit_prescaler u_prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .srcTick(srcTick),
        .divSel(st_reg.cfg.prescale),
        .divTick(divTick)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        st_next = st_reg;
        st_next.softReset = 1'b0;
        // A write during busy is dropped; software is expected to poll first
        acceptNow = !st_reg.busy && (ctlWrite || reloadWrite);
        commitNow = divTick && st_reg.busy;
        restartNow = commitNow && st_reg.pendCtlValid
            && (st_reg.pendCtl.restartKey == cdwit_pkg::RESTART_KEY);
        clearNow = commitNow && st_reg.pendCtlValid && st_reg.pendCtl.clearFlag;
        reloadNew = (commitNow && st_reg.pendReloadValid) ? st_reg.pendReload : st_reg.reload;
        runNow = st_reg.cfg.intervalEn || st_reg.cfg.resetEn;
        expiryNow = 1'b0;

        if (acceptNow)
        begin
            st_next.busy = 1'b1;
            if (ctlWrite)
            begin
                st_next.pendCtl = ctlWriteData;
                st_next.pendCtlValid = 1'b1;
            end
            if (reloadWrite)
            begin
                st_next.pendReload = reloadWriteData;
                st_next.pendReloadValid = 1'b1;
            end
        end

        if (commitNow)
        begin
            st_next.busy = 1'b0;
            st_next.pendCtlValid = 1'b0;
            st_next.pendReloadValid = 1'b0;
            st_next.reload = reloadNew;
            if (st_reg.pendCtlValid)
            begin
                st_next.cfg = st_reg.pendCtl;
                st_next.cfg.restartKey = '0;
                st_next.cfg.clearFlag = 1'b0;
            end
        end

        if (divTick)
        begin
            if (restartNow)
            begin
                st_next.count = reloadNew;
                st_next.phase = cdwit_pkg::PH_ARMED;
            end
            else if (runNow)
            begin
                if (st_reg.count == cdwit_pkg::COUNT_ZERO)
                begin
                    st_next.count = st_reg.reload;
                end
                else
                begin
                    st_next.count = st_reg.count - cdwit_pkg::COUNT_STEP;
                    expiryNow = (st_reg.count == cdwit_pkg::COUNT_STEP);
                end
            end
        end

        // Set wins over a clear that lands on the same tick
        if (clearNow)
            st_next.flag = 1'b0;
        if (expiryNow && st_reg.cfg.intervalEn)
            st_next.flag = 1'b1;

        if (expiryNow && st_reg.cfg.resetEn)
        begin
            if (st_reg.cfg.intervalEn && st_reg.phase == cdwit_pkg::PH_ARMED)
            begin
                st_next.phase = cdwit_pkg::PH_WARNED;
            end
            else
            begin
                st_next.softReset = 1'b1;
                st_next.phase = cdwit_pkg::PH_ARMED;
            end
        end
        if (!st_next.cfg.resetEn)
            st_next.phase = cdwit_pkg::PH_ARMED;

        st_next.irq = st_next.flag;
        st_next.wake = st_next.flag && deepSleep;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            st_reg <= STATE_RESET;
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign liveCount = st_reg.count;
    assign reloadValue = st_reg.reload;
    assign ctlStatus = '{
        writePending: st_reg.busy,
        irqFlag: st_reg.flag,
        prescale: st_reg.cfg.prescale,
        clkSel: st_reg.cfg.clkSel,
        resetEn: st_reg.cfg.resetEn,
        intervalEn: st_reg.cfg.intervalEn
    };
    assign irqReq = st_reg.irq;
    assign wakeReq = st_reg.wake;
    assign softReset = st_reg.softReset;

    ////////////////////////////////////////////////////////////////////////////////

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_first_expiry;
        expiryNow && st_reg.cfg.intervalEn && st_reg.cfg.resetEn
            && st_reg.phase == cdwit_pkg::PH_ARMED;
    endsequence

    sequence s_flagged_wait;
        irqReq && !softReset;
    endsequence

    chk_write_sets_busy: assert property (acceptNow |=> ctlStatus.writePending)
        else $error("Accepted write did not raise busy");

    chk_busy_holds: assert property (ctlStatus.writePending && !divTick
        |=> ctlStatus.writePending)
        else $error("Busy dropped without a divided tick");

    chk_commit_frees: assert property (commitNow |=> !ctlStatus.writePending)
        else $error("Busy stayed after commit");

    chk_count_step: assert property (divTick && !restartNow && runNow
        && liveCount != cdwit_pkg::COUNT_ZERO
        |=> liveCount == $past(liveCount) - cdwit_pkg::COUNT_STEP)
        else $error("Count did not step down by one");

    chk_count_holds: assert property (!divTick |=> liveCount == $past(liveCount))
        else $error("Count moved without a divided tick");

    chk_count_reload: assert property (divTick && !restartNow && runNow
        && liveCount == cdwit_pkg::COUNT_ZERO
        |=> liveCount == $past(reloadValue))
        else $error("Count did not reload after zero");

    chk_restart_load: assert property (restartNow |=> liveCount == $past(reloadNew))
        else $error("Restart did not load reload value");

    chk_flag_set: assert property (expiryNow && ctlStatus.intervalEn
        |=> ctlStatus.irqFlag && irqReq)
        else $error("Expiry did not set the interval flag");

    chk_irq_follows: assert property (irqReq == ctlStatus.irqFlag)
        else $error("Interrupt request differs from flag");

    chk_flag_clear: assert property (clearNow && !expiryNow |=> !irqReq)
        else $error("Interrupt request stayed after clear");

    chk_wd_reset: assert property (expiryNow && ctlStatus.resetEn
        && !ctlStatus.intervalEn |=> softReset ##1 !softReset)
        else $error("Watchdog expiry gave no one-cycle soft reset");

    chk_combined_warn: assert property (s_first_expiry |=> s_flagged_wait)
        else $error("First combined expiry must flag without reset");

    chk_sleep_gate: assert property (deepSleep
        && ctlStatus.clkSel == cdwit_pkg::CLKSEL_PLL |-> !srcTick)
        else $error("PLL source ticked during deep sleep");

    chk_wake_flag: assert property (wakeReq |-> irqReq && $past(deepSleep))
        else $error("Wake request without interrupt flag and sleep");

    chk_src_ref: assert property (ctlStatus.clkSel == cdwit_pkg::CLKSEL_REF
        |-> srcTick == tickRef)
        else $error("Reference source not selected");

    // Neither the reload value nor the control fields may move between commits
    chk_reload_stable: assert property (!commitNow |=> $stable(reloadValue))
        else $error("Reload value moved outside a commit");

    chk_cfg_stable: assert property (!commitNow |=> $stable(st_reg.cfg))
        else $error("Control fields moved outside a commit");

    chk_reload_commit: assert property (commitNow && st_reg.pendReloadValid
        |=> reloadValue == $past(st_reg.pendReload))
        else $error("Pending reload was not committed");

    chk_cfg_commit: assert property (commitNow && st_reg.pendCtlValid
        |=> ctlStatus.intervalEn == $past(st_reg.pendCtl.intervalEn)
        && ctlStatus.resetEn == $past(st_reg.pendCtl.resetEn))
        else $error("Pending control enables were not committed");

    chk_idle_hold: assert property (divTick && !restartNow && !runNow
        |=> $stable(liveCount))
        else $error("Count moved with both enables off");

    chk_flag_sticky: assert property (ctlStatus.irqFlag && !clearNow
        |=> ctlStatus.irqFlag)
        else $error("Interval flag dropped without a clear");

    chk_restart_arms: assert property (restartNow
        |=> st_reg.phase == cdwit_pkg::PH_ARMED)
        else $error("Restart did not rearm the watchdog phase");

    // A commit that drops the reset enable on the same tick rearms instead
    chk_warn_phase: assert property (s_first_expiry
        |=> st_reg.phase == cdwit_pkg::PH_WARNED || !ctlStatus.resetEn)
        else $error("First combined expiry did not enter the warned phase");

    chk_soft_pulse: assert property (softReset |=> !softReset)
        else $error("Soft reset longer than one cycle");

    chk_soft_cause: assert property (softReset |-> $past(expiryNow))
        else $error("Soft reset without an expiry");

endmodule

// File: cdwit_tick_model.sv
// Model of the two timer clock sources that feed the tick enables
module cdwit_tick_model (
    input wire logic clock,
    input wire logic rst_n,
    output logic tickRef,
    output logic tickPll
);
    timeunit 1ns;
    timeprecision 100ps;

    logic pllPhase_reg;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pllPhase_reg <= 1'b0;
        end
        else
        begin
            pllPhase_reg <= ~pllPhase_reg;
        end
    end

    // Reference source ticks every cycle once out of reset, so it can still wake the core
    assign tickRef = rst_n;
    // Left running in sleep so that only the timer's own gating can stop the count
    assign tickPll = pllPhase_reg;
endmodule

// File: cdwit_timer_tb.sv
// Self-checking bench of the countdown watchdog / interval timer
`define CDWIT_CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module cdwit_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock;
    logic rst_n;
    logic tickRef;
    logic tickPll;
    logic deepSleep;
    logic ctlWrite;
    cdwit_pkg::cdwit_ctl_t ctlWriteData;
    logic reloadWrite;
    logic [cdwit_pkg::COUNT_W-1:0] reloadWriteData;
    logic [cdwit_pkg::COUNT_W-1:0] liveCount;
    logic [cdwit_pkg::COUNT_W-1:0] reloadValue;
    logic [cdwit_pkg::COUNT_W-1:0] held;
    cdwit_pkg::cdwit_ctl_t cw;
    cdwit_pkg::cdwit_status_t ctlStatus;
    logic irqReq;
    logic wakeReq;
    logic softReset;
    int n_mismatch = 0;
    int checks_done = 0;
    int softSeen;
    int cyc;

    cdwit_tick_model u_src (.clock(clock), .rst_n(rst_n), .tickRef(tickRef),
        .tickPll(tickPll));

    cdwit_timer u_dut (.clock(clock), .rst_n(rst_n), .tickRef(tickRef), .tickPll(tickPll),
        .deepSleep(deepSleep), .ctlWrite(ctlWrite), .ctlWriteData(ctlWriteData),
        .reloadWrite(reloadWrite), .reloadWriteData(reloadWriteData),
        .liveCount(liveCount), .reloadValue(reloadValue), .ctlStatus(ctlStatus),
        .irqReq(irqReq), .wakeReq(wakeReq), .softReset(softReset));

    always #(cdwit_pkg::CLOCK_PERIOD_NS / 2) clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (n_mismatch == 0 && checks_done > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Inputs move 1 ns after the edge so the design samples settled values
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    function automatic logic hit(input int which);
        case (which)
            0: return ctlStatus.writePending === 1'b0;
            1: return irqReq === 1'b1;
            default: return softReset === 1'b1;
        endcase
    endfunction

    // Bounded wait; soft reset pulses seen on the way are counted
    task automatic wait_on(input int which, input int lim);
        int n;
        n = 0;
        while (!hit(which) && n < lim)
        begin
            step(1);
            n++;
            if (softReset === 1'b1)
            begin
                softSeen++;
            end
        end
        if (!hit(which))
        begin
            n_mismatch++;
            final_report();
        end
    endtask

    task automatic wait_change(output int c);
        logic [cdwit_pkg::COUNT_W-1:0] v;
        v = liveCount;
        c = 0;
        while (liveCount === v && c < 300)
        begin
            step(1);
            c++;
        end
        if (liveCount === v)
        begin
            n_mismatch++;
            final_report();
        end
    endtask

    function automatic cdwit_pkg::cdwit_ctl_t mk(input logic iEn, input logic rEn,
        input logic sel, input logic [cdwit_pkg::PRESCALE_W-1:0] ps, input logic clr);
        cdwit_pkg::cdwit_ctl_t c;
        c.restartKey = cdwit_pkg::RESTART_KEY;
        c.clearFlag = clr;
        c.prescale = ps;
        c.clkSel = sel;
        c.resetEn = rEn;
        c.intervalEn = iEn;
        return c;
    endfunction

    // One write, then poll the pending flag before anything else is sent
    task automatic wr_ctl(input cdwit_pkg::cdwit_ctl_t c);
        ctlWrite = 1'b1;
        ctlWriteData = c;
        step(1);
        ctlWrite = 1'b0;
        `CDWIT_CHK(ctlStatus.writePending, 1'b1)
        wait_on(0, 300);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        deepSleep = 1'b0;
        ctlWrite = 1'b0;
        ctlWriteData = '0;
        reloadWrite = 1'b0;
        reloadWriteData = 24'h00_0000;
        softSeen = 0;
        step(8);
        `CDWIT_CHK(liveCount, cdwit_pkg::RELOAD_RESET)
        `CDWIT_CHK(ctlStatus, 9'h000)
        rst_n = 1'b1;
        step(1);
        // Second strobe lands while pending and must be dropped
        reloadWrite = 1'b1;
        reloadWriteData = 24'h00_0003;
        step(1);
        reloadWriteData = 24'h00_0007;
        step(1);
        reloadWrite = 1'b0;
        wait_on(0, 300);
        `CDWIT_CHK(reloadValue, 24'h00_0003)
        wr_ctl(mk(1'b1, 1'b0, cdwit_pkg::CLKSEL_REF, 4'h0, 1'b0));
        `CDWIT_CHK(liveCount, 24'h00_0003)
        wait_on(1, 40);
        `CDWIT_CHK(liveCount, 24'h00_0000)
        `CDWIT_CHK(ctlStatus.irqFlag, 1'b1)
        wait_change(cyc);
        `CDWIT_CHK(liveCount, 24'h00_0003)
        wr_ctl(mk(1'b0, 1'b0, cdwit_pkg::CLKSEL_REF, 4'h0, 1'b1));
        `CDWIT_CHK(irqReq, 1'b0)
        // Tick spacing follows the prescale code
        for (int n = 0; n < 3; n++)
        begin
            wr_ctl(mk(1'b1, 1'b0, cdwit_pkg::CLKSEL_REF, n[3:0], 1'b1));
            wait_change(cyc);
            wait_change(cyc);
            `CDWIT_CHK(cyc, 2 << n)
        end
        // Watchdog alone: no interrupt, just the soft reset
        wr_ctl(mk(1'b0, 1'b0, cdwit_pkg::CLKSEL_REF, 4'h0, 1'b1));
        wr_ctl(mk(1'b0, 1'b1, cdwit_pkg::CLKSEL_REF, 4'h0, 1'b0));
        wait_on(2, 40);
        `CDWIT_CHK(softReset, 1'b1)
        `CDWIT_CHK(irqReq, 1'b0)
        // Both on: first expiry only flags, second expiry resets
        wr_ctl(mk(1'b1, 1'b1, cdwit_pkg::CLKSEL_REF, 4'h0, 1'b1));
        softSeen = 0;
        wait_on(1, 40);
        `CDWIT_CHK(softSeen, 0)
        // Clear without the key: no restart, so the very next expiry must reset
        cw = mk(1'b1, 1'b1, cdwit_pkg::CLKSEL_REF, 4'h0, 1'b1);
        cw.restartKey = 8'h00;
        wr_ctl(cw);
        `CDWIT_CHK(irqReq, 1'b0)
        wait_on(2, 10);
        `CDWIT_CHK(softReset, 1'b1)
        // PLL source halts in deep sleep, reference source keeps going
        wr_ctl(mk(1'b1, 1'b0, cdwit_pkg::CLKSEL_PLL, 4'h0, 1'b1));
        `CDWIT_CHK(ctlStatus.clkSel, cdwit_pkg::CLKSEL_PLL)
        deepSleep = 1'b1;
        step(1);
        held = liveCount;
        step(12);
        `CDWIT_CHK(liveCount, held)
        deepSleep = 1'b0;
        step(12);
        `CDWIT_CHK(liveCount !== held, 1'b1)
        wr_ctl(mk(1'b1, 1'b0, cdwit_pkg::CLKSEL_REF, 4'h0, 1'b1));
        deepSleep = 1'b1;
        wait_on(1, 40);
        step(2);
        `CDWIT_CHK(wakeReq, 1'b1)
        deepSleep = 1'b0;
        wr_ctl(mk(1'b0, 1'b0, cdwit_pkg::CLKSEL_REF, 4'hF, 1'b1));
        `CDWIT_CHK(ctlStatus.prescale, 4'hF)
        final_report();
    end
endmodule
